// ### rtl/mior_defs.svh
// constants for the miscellaneous i/o, serial port and rom read block
// assumes a 50 MHz clock and an axi4-lite register bus with 32-bit data
// Behaviour
// - mode one drives register bits onto pins
// - mode zero strobes latch on each general output write with byte 0 strobed
// - serial clock pin driven from bit 0
// - serial clock level read in bit 2
// - serial data pin driven from bit 1
// - serial data level read in bit 3
// - serial pins work only while bit 4 set
// - strapped alias port reaches serial register
// - rom read drives 16-bit address out
// - rom read captures 8-bit data
// - rom enable asserted during rom read
`ifndef MIOR_DEFS_SVH
`define MIOR_DEFS_SVH
// ==========================================================
// register offsets (byte addresses)
`define MIOR_OFF_GEN_OUT 8'h00
`define MIOR_OFF_MODE 8'h04
`define MIOR_OFF_SERIAL 8'h08
`define MIOR_OFF_ROM_ADDR 8'h0C
`define MIOR_OFF_ROM_STAT 8'h10
`define MIOR_OFF_STRAP 8'h14
// ==========================================================
// field positions
`define MIOR_SER_CLK_OUT 0
`define MIOR_SER_DAT_OUT 1
`define MIOR_SER_CLK_IN 2
`define MIOR_SER_DAT_IN 3
`define MIOR_SER_EN 4
`define MIOR_MODE_SEL 0
`define MIOR_ROM_BUSY 8
// ==========================================================
// alias ports and straps
`define MIOR_IO_PORT_A 16'h00E2
`define MIOR_IO_PORT_B 16'h00E8
`define MIOR_STRAP_PORT_A 2'h1
`define MIOR_STRAP_PORT_B 2'h2
// ==========================================================
// responses and timing
`define MIOR_RESP_OKAY 2'h0
`define MIOR_RESP_SLVERR 2'h2
`define MIOR_CLK_NS 20
`define MIOR_ROM_ACC_NS 200
`endif

// ### rtl/mior_pkg.sv
// types for the miscellaneous i/o, serial port and rom read block
// assumes mior_defs.svh supplies the numeric constants
package mior_pkg;
   typedef enum logic [0:0] {
      MIOR_ROM_IDLE,
      MIOR_ROM_ACCESS
   } mior_rom_state_t;
endpackage

// ### rtl/mior_od_pin.sv
// one open-drain serial pin cell with registered enable and level
// assumes the pin input is synchronous to i_clk
`timescale 1ns/1ps
module mior_od_pin (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_en,
   input wire logic i_out_bit,
   input wire logic i_pin,
   output logic o_pin_out,
   output logic o_pin_oe,
   output logic o_level
);
   logic next_oe;
   logic next_level;
   // ==========================================================
   // drive low for a zero, release for a one, only when enabled
   always_comb begin
      next_oe = i_en & ~i_out_bit;
      next_level = i_en & i_pin;
   end
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_pin_out <= 1'b0;
         o_pin_oe <= 1'b0;
         o_level <= 1'b0;
      end else begin
         // open drain: the driven level is always low
         o_pin_out <= 1'b0;
         o_pin_oe <= next_oe;
         o_level <= next_level;
      end
   end
endmodule // mior_od_pin

// ### rtl/mior_top.sv
// miscellaneous i/o block: general output port, serial port, rom reads
// assumes axi4-lite master on i_clk, synchronous active-high reset
`timescale 1ns/1ps
`include "mior_defs.svh"
module mior_top
   import mior_pkg::*;
#(
   parameter int ROM_ACC_NS = `MIOR_ROM_ACC_NS
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [7:0] i_s_awaddr,
   input wire logic i_s_awvalid,
   output logic o_s_awready,
   input wire logic [31:0] i_s_wdata,
   input wire logic [3:0] i_s_wstrb,
   input wire logic i_s_wvalid,
   output logic o_s_wready,
   output logic [1:0] o_s_bresp,
   output logic o_s_bvalid,
   input wire logic i_s_bready,
   input wire logic [7:0] i_s_araddr,
   input wire logic i_s_arvalid,
   output logic o_s_arready,
   output logic [31:0] o_s_rdata,
   output logic [1:0] o_s_rresp,
   output logic o_s_rvalid,
   input wire logic i_s_rready,
   input wire logic [15:0] i_io_addr,
   input wire logic i_io_wr,
   input wire logic i_io_rd,
   input wire logic [7:0] i_io_wdata,
   output logic [7:0] o_io_rdata,
   output logic o_io_hit,
   input wire logic [1:0] i_mem_data_bus_strap,
   output logic [1:0] o_gen_out,
   output logic o_out_latch_strobe,
   input wire logic i_ser_clk,
   output logic o_ser_clk,
   output logic o_ser_clk_oe,
   input wire logic i_ser_dat,
   output logic o_ser_dat,
   output logic o_ser_dat_oe,
   output logic [15:0] o_rom_addr,
   output logic o_rom_addr_oe,
   input wire logic [7:0] i_rom_data,
   output logic o_rom_oe
);
   localparam int ROM_CYC_RAW = (ROM_ACC_NS + `MIOR_CLK_NS - 1) / `MIOR_CLK_NS;
   localparam int ROM_CYC = (ROM_CYC_RAW < 1) ? 1 : ROM_CYC_RAW;
   localparam int CW = $clog2(ROM_CYC + 1);
   localparam logic [CW-1:0] ROM_LAST = CW'(ROM_CYC - 1);

   // ==========================================================
   // helpers
   function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic is_mapped(input logic [7:0] a);
      return (a == `MIOR_OFF_GEN_OUT) || (a == `MIOR_OFF_MODE) ||
         (a == `MIOR_OFF_SERIAL) || (a == `MIOR_OFF_ROM_ADDR) ||
         (a == `MIOR_OFF_ROM_STAT) || (a == `MIOR_OFF_STRAP);
   endfunction

   // ==========================================================
   // state
   logic [7:0] aw_addr, next_aw_addr;
   logic aw_have, next_aw_have;
   logic [31:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic w_have, next_w_have;
   logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic [1:0] gen_out_reg, next_gen_out_reg;
   logic outport_mode_sel, next_outport_mode_sel;
   logic [4:0] serial_port_reg, next_serial_port_reg;
   logic [1:0] strap, next_strap;
   logic strap_done, next_strap_done;
   logic [1:0] next_gen_out;
   logic next_strobe;
   mior_rom_state_t rom_state, next_rom_state;
   logic [CW-1:0] rom_cnt, next_rom_cnt;
   logic [15:0] next_rom_addr;
   logic [7:0] rom_data, next_rom_data;
   logic next_rom_oe;
   logic [7:0] next_io_rdata;
   logic next_io_hit;
   logic [1:0] ser_level;
   logic [1:0] ser_oe;
   logic [1:0] ser_out;
   logic [1:0] ser_pin_in;
   logic do_write;
   logic io_sel;
   logic [31:0] wr_val;
   logic [31:0] ser_word;
   logic [31:0] rom_wr_val;

   assign ser_pin_in = {i_ser_dat, i_ser_clk};
   assign rom_wr_val = merge_strb({16'h0000, o_rom_addr}, w_data, w_strb);
   assign ser_word = {27'h0000000, serial_port_reg[`MIOR_SER_EN], ser_level,
      serial_port_reg[`MIOR_SER_DAT_OUT], serial_port_reg[`MIOR_SER_CLK_OUT]};

   // ==========================================================
   // serial pins
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_ser
         mior_od_pin u_pin (
            .i_clk(i_clk),
            .i_rst(i_rst),
            .i_en(serial_port_reg[`MIOR_SER_EN]),
            .i_out_bit(serial_port_reg[gi]),
            .i_pin(ser_pin_in[gi]),
            .o_pin_out(ser_out[gi]),
            .o_pin_oe(ser_oe[gi]),
            .o_level(ser_level[gi])
         );
      end
   endgenerate
   assign o_ser_clk = ser_out[0];
   assign o_ser_clk_oe = ser_oe[0];
   assign o_ser_dat = ser_out[1];
   assign o_ser_dat_oe = ser_oe[1];

   // ==========================================================
   // strap capture after reset release
   always_comb begin
      next_strap = strap;
      next_strap_done = 1'b1;
      if (!strap_done) begin
         next_strap = i_mem_data_bus_strap;
      end
   end

   // ==========================================================
   // alias port decode
   always_comb begin
      io_sel = 1'b0;
      if (strap_done && (strap == `MIOR_STRAP_PORT_A) && (i_io_addr == `MIOR_IO_PORT_A)) begin
         io_sel = 1'b1;
      end
      if (strap_done && (strap == `MIOR_STRAP_PORT_B) && (i_io_addr == `MIOR_IO_PORT_B)) begin
         io_sel = 1'b1;
      end
      next_io_hit = io_sel & (i_io_rd | i_io_wr);
      next_io_rdata = o_io_rdata;
      if (io_sel && i_io_rd) begin
         next_io_rdata = ser_word[7:0];
      end
   end

   // ==========================================================
   // axi write channel and register writes
   always_comb begin
      next_aw_addr = aw_addr;
      next_aw_have = aw_have;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_w_have = w_have;
      next_bvalid = o_s_bvalid;
      next_bresp = o_s_bresp;
      next_gen_out_reg = gen_out_reg;
      next_outport_mode_sel = outport_mode_sel;
      next_serial_port_reg = serial_port_reg;
      next_strobe = 1'b0;
      wr_val = 32'h00000000;
      if (o_s_bvalid && i_s_bready) begin
         next_bvalid = 1'b0;
      end
      if (o_s_awready && i_s_awvalid) begin
         next_aw_addr = i_s_awaddr;
         next_aw_have = 1'b1;
      end
      if (o_s_wready && i_s_wvalid) begin
         next_w_data = i_s_wdata;
         next_w_strb = i_s_wstrb;
         next_w_have = 1'b1;
      end
      do_write = aw_have && w_have && !o_s_bvalid;
      if (io_sel && i_io_wr) begin
         next_serial_port_reg = {i_io_wdata[`MIOR_SER_EN], 2'h0,
            i_io_wdata[`MIOR_SER_DAT_OUT], i_io_wdata[`MIOR_SER_CLK_OUT]};
      end
      if (do_write) begin
         next_aw_have = 1'b0;
         next_w_have = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = is_mapped(aw_addr) ? `MIOR_RESP_OKAY : `MIOR_RESP_SLVERR;
         unique case (aw_addr)
            `MIOR_OFF_GEN_OUT: begin
               wr_val = merge_strb({30'h00000000, gen_out_reg}, w_data, w_strb);
               next_gen_out_reg = wr_val[1:0];
               next_strobe = !outport_mode_sel && w_strb[0];
            end
            `MIOR_OFF_MODE: begin
               wr_val = merge_strb({31'h00000000, outport_mode_sel}, w_data, w_strb);
               next_outport_mode_sel = wr_val[`MIOR_MODE_SEL];
            end
            `MIOR_OFF_SERIAL: begin
               wr_val = merge_strb(ser_word, w_data, w_strb);
               next_serial_port_reg = {wr_val[`MIOR_SER_EN], 2'h0,
                  wr_val[`MIOR_SER_DAT_OUT], wr_val[`MIOR_SER_CLK_OUT]};
            end
            default: begin
               wr_val = 32'h00000000;
            end
         endcase
      end
      next_awready = !next_aw_have && !next_bvalid;
      next_wready = !next_w_have && !next_bvalid;
   end

   // ==========================================================
   // general output port pins
   always_comb begin
      next_gen_out = outport_mode_sel ? gen_out_reg : 2'h0;
   end

   // ==========================================================
   // rom read sequencer
   always_comb begin
      next_rom_state = rom_state;
      next_rom_cnt = rom_cnt;
      next_rom_addr = o_rom_addr;
      next_rom_data = rom_data;
      next_rom_oe = 1'b0;
      unique case (rom_state)
         MIOR_ROM_IDLE: begin
            // software keeps the memory bus idle before starting a read
            if (do_write && (aw_addr == `MIOR_OFF_ROM_ADDR)) begin
               next_rom_addr = rom_wr_val[15:0];
               next_rom_cnt = '0;
               next_rom_oe = 1'b1;
               next_rom_state = MIOR_ROM_ACCESS;
            end
         end
         MIOR_ROM_ACCESS: begin
            next_rom_oe = 1'b1;
            next_rom_cnt = CW'(rom_cnt + 1'b1);
            if (rom_cnt == ROM_LAST) begin
               next_rom_data = i_rom_data;
               next_rom_oe = 1'b0;
               next_rom_state = MIOR_ROM_IDLE;
            end
         end
      endcase
   end

   // ==========================================================
   // axi read channel
   always_comb begin
      next_rvalid = o_s_rvalid;
      next_rdata = o_s_rdata;
      next_rresp = o_s_rresp;
      if (o_s_rvalid && i_s_rready) begin
         next_rvalid = 1'b0;
      end
      if (o_s_arready && i_s_arvalid) begin
         next_rvalid = 1'b1;
         next_rresp = is_mapped(i_s_araddr) ? `MIOR_RESP_OKAY : `MIOR_RESP_SLVERR;
         unique case (i_s_araddr)
            `MIOR_OFF_GEN_OUT: next_rdata = {30'h00000000, gen_out_reg};
            `MIOR_OFF_MODE: next_rdata = {31'h00000000, outport_mode_sel};
            `MIOR_OFF_SERIAL: next_rdata = ser_word;
            `MIOR_OFF_ROM_ADDR: next_rdata = {16'h0000, o_rom_addr};
            `MIOR_OFF_ROM_STAT: next_rdata = {23'h000000,
               rom_state == MIOR_ROM_ACCESS, rom_data};
            `MIOR_OFF_STRAP: next_rdata = {29'h00000000, strap_done, strap};
            default: next_rdata = 32'h00000000;
         endcase
      end
      next_arready = !next_rvalid;
   end

   // ==========================================================
   // registers
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         aw_addr <= 8'h00;
         aw_have <= 1'b0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         w_have <= 1'b0;
         o_s_awready <= 1'b0;
         o_s_wready <= 1'b0;
         o_s_bvalid <= 1'b0;
         o_s_bresp <= `MIOR_RESP_OKAY;
         o_s_arready <= 1'b0;
         o_s_rvalid <= 1'b0;
         o_s_rdata <= 32'h00000000;
         o_s_rresp <= `MIOR_RESP_OKAY;
         gen_out_reg <= 2'h0;
         outport_mode_sel <= 1'b0;
         serial_port_reg <= 5'h00;
         strap <= 2'h0;
         strap_done <= 1'b0;
         o_gen_out <= 2'h0;
         o_out_latch_strobe <= 1'b0;
         rom_state <= MIOR_ROM_IDLE;
         rom_cnt <= '0;
         o_rom_addr <= 16'h0000;
         rom_data <= 8'h00;
         o_rom_oe <= 1'b0;
         o_rom_addr_oe <= 1'b0;
         o_io_rdata <= 8'h00;
         o_io_hit <= 1'b0;
      end else begin
         aw_addr <= next_aw_addr;
         aw_have <= next_aw_have;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         w_have <= next_w_have;
         o_s_awready <= next_awready;
         o_s_wready <= next_wready;
         o_s_bvalid <= next_bvalid;
         o_s_bresp <= next_bresp;
         o_s_arready <= next_arready;
         o_s_rvalid <= next_rvalid;
         o_s_rdata <= next_rdata;
         o_s_rresp <= next_rresp;
         gen_out_reg <= next_gen_out_reg;
         outport_mode_sel <= next_outport_mode_sel;
         serial_port_reg <= next_serial_port_reg;
         strap <= next_strap;
         strap_done <= next_strap_done;
         o_gen_out <= next_gen_out;
         o_out_latch_strobe <= next_strobe;
         rom_state <= next_rom_state;
         rom_cnt <= next_rom_cnt;
         o_rom_addr <= next_rom_addr;
         rom_data <= next_rom_data;
         o_rom_oe <= next_rom_oe;
         o_rom_addr_oe <= next_rom_oe;
         o_io_rdata <= next_io_rdata;
         o_io_hit <= next_io_hit;
      end
   end
endmodule // mior_top

// ### testbench/mior_properties.sv
// checker for the misc i/o block, sees top ports only
// assumes synchronous active-high reset on i_clk
`timescale 1ns/1ps
module mior_chk #(
   parameter int ROM_ACC_NS = 200
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_io_wr,
   input wire logic i_io_rd,
   input wire logic o_s_bvalid,
   input wire logic [1:0] o_gen_out,
   input wire logic o_out_latch_strobe,
   input wire logic o_ser_clk,
   input wire logic o_ser_dat,
   input wire logic [15:0] o_rom_addr,
   input wire logic o_rom_addr_oe,
   input wire logic o_rom_oe,
   input wire logic o_io_hit
);
   localparam int ROM_CYC_RAW = (ROM_ACC_NS + 19) / 20;
   localparam int ROM_CYC = (ROM_CYC_RAW < 1) ? 1 : ROM_CYC_RAW;
   int run_cnt;
   int next_run_cnt;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // ==========================================
   // rom enable run length
   always_comb begin
      next_run_cnt = o_rom_oe ? run_cnt + 1 : 0;
   end
   always_ff @(posedge i_clk) begin
      run_cnt <= i_rst ? 0 : next_run_cnt;
   end
   // ==========================================
   // properties
   sequence s_rom_begin;
      $rose(o_rom_oe);
   endsequence
   sequence s_rom_busy;
      o_rom_oe ##1 o_rom_oe;
   endsequence
   property p_stb_one; o_out_latch_strobe |=> !o_out_latch_strobe; endproperty
   property p_stb_mode; o_out_latch_strobe |-> o_s_bvalid && o_gen_out == 2'h0; endproperty
   property p_od_low; o_ser_clk == 1'h0 && o_ser_dat == 1'h0; endproperty
   property p_rom_pair; o_rom_oe |-> o_rom_addr_oe; endproperty
   property p_rom_hold; s_rom_busy |-> $stable(o_rom_addr); endproperty
   property p_rom_start; s_rom_begin |-> o_s_bvalid; endproperty
   property p_rom_len; $fell(o_rom_oe) |-> run_cnt == ROM_CYC; endproperty
   property p_io_hit; o_io_hit |-> $past(i_io_wr || i_io_rd); endproperty
   a_stb_one: assert property (p_stb_one) else $error("strobe longer than one cycle");
   a_stb_mode: assert property (p_stb_mode) else $error("strobe off write");
   a_od_low: assert property (p_od_low) else $error("serial pin driven high");
   a_rom_pair: assert property (p_rom_pair) else $error("rom enable without address");
   a_rom_hold: assert property (p_rom_hold) else $error("rom address moved");
   a_rom_start: assert property (p_rom_start) else $error("rom read not on write");
   a_rom_len: assert property (p_rom_len) else $error("rom access length wrong");
   a_io_hit: assert property (p_io_hit) else $error("alias hit without access");
endmodule // mior_chk
bind mior_top mior_chk #(.ROM_ACC_NS(ROM_ACC_NS)) u_chk (.i_clk(i_clk), .i_rst(i_rst),
   .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .o_s_bvalid(o_s_bvalid), .o_gen_out(o_gen_out),
   .o_out_latch_strobe(o_out_latch_strobe), .o_ser_clk(o_ser_clk), .o_ser_dat(o_ser_dat),
   .o_rom_addr(o_rom_addr), .o_rom_addr_oe(o_rom_addr_oe), .o_rom_oe(o_rom_oe),
   .o_io_hit(o_io_hit));

// ### testbench/mior_far.sv
// far side: pulled-up serial wires and a slow rom
// assumes the block's enables pull the wires low
`timescale 1ns/1ps
module mior_far (
   input wire logic i_clk,
   input wire logic i_ser_clk_oe,
   input wire logic i_ser_dat_oe,
   input wire logic i_pull_dat,
   input wire logic [15:0] i_rom_addr,
   input wire logic i_rom_addr_oe,
   input wire logic i_rom_oe,
   output logic o_ser_clk,
   output logic o_ser_dat,
   output logic [7:0] o_rom_data
);
   int oe_cnt = 0;
   logic [7:0] last = 8'hA5;
   assign o_ser_clk = !i_ser_clk_oe;
   assign o_ser_dat = !(i_ser_dat_oe || i_pull_dat);
   // data valid only after a few enabled cycles, toggles otherwise
   assign o_rom_data = (i_rom_oe && i_rom_addr_oe && oe_cnt >= 3) ?
      (i_rom_addr[7:0] ^ i_rom_addr[15:8]) : ~last;
   always @(posedge i_clk) begin
      oe_cnt <= i_rom_oe ? oe_cnt + 1 : 0;
      last <= o_rom_data;
   end
endmodule // mior_far

// ### testbench/tb_top.sv
// self-checking bench for the misc i/o block
// assumes mior_top, mior_far and the bound checker
`timescale 1ns/1ps
`include "mior_defs.svh"
module tb_top;
   localparam logic [31:0] F = 32'hFFFFFFFF;
   localparam logic [1:0] OK = `MIOR_RESP_OKAY;
   logic i_clk, i_rst, awv, wv, bry, arv, rry, iow, ior, pd, awr, wr_r, bv, arr, rv;
   logic gstb, sc, sc_oe, sd, sd_oe, ra_oe, rom_oe, iohit, scw, sdw;
   logic [7:0] awa, ara, iod, iord, rom_d;
   logic [31:0] wd, rdat, q;
   logic [15:0] ioa, ra, a16;
   logic [1:0] strap, br, rr, gout, v;
   logic [65:0] rq[$], e;
   logic [1:0] bq[$];
   int errors = 0;
   int num_checks = 0;
   int stb_cnt = 0;
   mior_top DUT (.i_clk(i_clk), .i_rst(i_rst), .i_s_awaddr(awa), .i_s_awvalid(awv),
      .o_s_awready(awr), .i_s_wdata(wd), .i_s_wstrb(4'hF), .i_s_wvalid(wv),
      .o_s_wready(wr_r), .o_s_bresp(br), .o_s_bvalid(bv), .i_s_bready(bry),
      .i_s_araddr(ara), .i_s_arvalid(arv), .o_s_arready(arr), .o_s_rdata(rdat),
      .o_s_rresp(rr), .o_s_rvalid(rv), .i_s_rready(rry), .i_io_addr(ioa), .i_io_wr(iow),
      .i_io_rd(ior), .i_io_wdata(iod), .o_io_rdata(iord), .o_io_hit(iohit),
      .i_mem_data_bus_strap(strap), .o_gen_out(gout), .o_out_latch_strobe(gstb),
      .i_ser_clk(scw), .o_ser_clk(sc), .o_ser_clk_oe(sc_oe), .i_ser_dat(sdw), .o_ser_dat(sd),
      .o_ser_dat_oe(sd_oe), .o_rom_addr(ra), .o_rom_addr_oe(ra_oe), .i_rom_data(rom_d),
      .o_rom_oe(rom_oe));
   mior_far u_far (.i_clk(i_clk), .i_ser_clk_oe(sc_oe), .i_ser_dat_oe(sd_oe),
      .i_pull_dat(pd), .i_rom_addr(ra), .i_rom_addr_oe(ra_oe), .i_rom_oe(rom_oe),
      .o_ser_clk(scw), .o_ser_dat(sdw), .o_rom_data(rom_d));
   // ==========================================
   // compare, verdict, bus tasks
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      num_checks++;
      if (g !== x) begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic aw_p, w_p;
      aw_p = 1'h1;
      w_p = 1'h1;
      @(posedge i_clk);
      bq.push_back(r);
      awa <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      bry <= 1'h1;
      while (aw_p || w_p) begin
         @(posedge i_clk);
         if (aw_p && awr) begin
            aw_p = 1'h0;
            awv <= 1'h0;
         end
         if (w_p && wr_r) begin
            w_p = 1'h0;
            wv <= 1'h0;
         end
      end
      do @(posedge i_clk); while (!bv);
      bry <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [65:0] x, output logic [31:0] d);
      @(posedge i_clk);
      rq.push_back(x);
      ara <= a;
      arv <= 1'h1;
      rry <= 1'h1;
      do @(posedge i_clk); while (!arr);
      arv <= 1'h0;
      do @(posedge i_clk); while (!rv);
      d = rdat;
      rry <= 1'h0;
   endtask
   task automatic io(input logic [15:0] a, input logic w, input logic [7:0] d, input logic h);
      @(posedge i_clk);
      ioa <= a;
      iod <= d;
      iow <= w;
      ior <= !w;
      @(posedge i_clk);
      iow <= 1'h0;
      ior <= 1'h0;
      @(negedge i_clk);
      chk("io_hit", 32'(h), 32'(iohit));
   endtask
   task automatic ser(input logic [31:0] w, input logic [1:0] oe, input logic [31:0] x);
      wr(`MIOR_OFF_SERIAL, w, OK);
      repeat (3) @(negedge i_clk);
      chk("ser_oe", 32'(oe), 32'({sd_oe, sc_oe}));
      rd(`MIOR_OFF_SERIAL, {F, OK, x}, q);
   endtask
   // ==========================================
   // result watcher and stimulus
   always @(posedge i_clk) begin
      if (gstb) stb_cnt++;
      if (rv && rry && rq.size() > 0) begin
         e = rq.pop_front();
         chk("rdata", e[31:0] & e[65:34], rdat & e[65:34]);
         chk("rresp", 32'(e[33:32]), 32'(rr));
      end
      if (bv && bry && bq.size() > 0) chk("bresp", 32'(bq.pop_front()), 32'(br));
   end
   initial begin
      i_clk = 1'h0;
      forever #10 i_clk = ~i_clk;
   end
   initial begin
      repeat (5000) @(posedge i_clk);
      errors++;
      $display("BAD watchdog expected done seen hang");
      end_of_test;
   end
   initial begin
      {i_rst, pd, strap} = {1'h1, 1'h0, `MIOR_STRAP_PORT_A};
      {awv, wv, bry, arv, rry, iow, ior, awa, ara, iod, ioa, wd} = '0;
      void'($urandom(66));
      repeat (6) @(posedge i_clk);
      i_rst <= 1'h0;
      rd(`MIOR_OFF_GEN_OUT, {F, OK, 32'h0}, q);
      rd(`MIOR_OFF_STRAP, {F, OK, 32'h5}, q);
      rd(8'h18, {32'h0, `MIOR_RESP_SLVERR, 32'h0}, q);
      wr(8'h18, 32'h1, `MIOR_RESP_SLVERR);
      $display("test reset and map done");
      v = 2'($urandom());
      wr(`MIOR_OFF_GEN_OUT, 32'(v), OK);
      @(negedge i_clk);
      chk("strobe_count", 32'h1, 32'(stb_cnt));
      chk("gen_out", 32'h0, 32'(gout));
      wr(`MIOR_OFF_MODE, 32'h1, OK);
      v = ~v;
      wr(`MIOR_OFF_GEN_OUT, 32'(v), OK);
      @(negedge i_clk);
      chk("gen_out", 32'(v), 32'(gout));
      chk("strobe_count", 32'h1, 32'(stb_cnt));
      $display("test output port done");
      ser(32'h10, 2'h3, 32'h10);
      ser(32'h13, 2'h0, 32'h1F);
      @(posedge i_clk);
      pd <= 1'h1;
      repeat (3) @(posedge i_clk);
      rd(`MIOR_OFF_SERIAL, {F, OK, 32'h17}, q);
      @(posedge i_clk);
      pd <= 1'h0;
      ser(32'h03, 2'h0, 32'h03);
      $display("test serial port done");
      io(`MIOR_IO_PORT_A, 1'h1, 8'h11, 1'h1);
      repeat (3) @(posedge i_clk);
      io(`MIOR_IO_PORT_A, 1'h0, 8'h00, 1'h1);
      chk("io_rdata", 32'h15, 32'(iord));
      io(`MIOR_IO_PORT_B, 1'h1, 8'h00, 1'h0);
      rd(`MIOR_OFF_SERIAL, {F, OK, 32'h15}, q);
      $display("test alias port done");
      a16 = 16'($urandom());
      wr(`MIOR_OFF_ROM_ADDR, 32'(a16), OK);
      wr(`MIOR_OFF_ROM_ADDR, 32'(~a16), OK);
      q = 32'h100;
      while (q[8]) rd(`MIOR_OFF_ROM_STAT, {32'h0, OK, 32'h0}, q);
      rd(`MIOR_OFF_ROM_STAT, {F, OK, 32'(a16[7:0] ^ a16[15:8])}, q);
      chk("rom_addr", 32'(a16), 32'(ra));
      $display("test rom read done");
      end_of_test;
   end
endmodule // tb_top
